// file: rtl/ees_cfg.svh
// Purpose: constants for the serial EEPROM slave front end
// Assumes: 100 MHz system clock
// Notes: times are kept in their own units, counts derived from them
`ifndef EES_CFG_SVH
`define EES_CFG_SVH
`define EES_TYPE_ID 4'hA
`define EES_NOSTRAP_SEL 3'h0
`define EES_ERASED 8'hFF
`define EES_ADDR_W 13
`define EES_PAGE_W 5
`define EES_CLK_NS 10
`define EES_PROG_TIME_NS 4000000
`define EES_PROG_CYCLES (`EES_PROG_TIME_NS / `EES_CLK_NS)
`endif

// file: rtl/ees_pkg.sv
// Purpose: types shared by the serial EEPROM slave
// Assumes: one-hot protocol states
// Notes: constants live in ees_cfg.svh
package ees_pkg;
  typedef enum logic [5:0] {
    EES_IDLE = 6'h01,
    EES_DEVA = 6'h02,
    EES_AHI = 6'h04,
    EES_ALO = 6'h08,
    EES_WDAT = 6'h10,
    EES_RDAT = 6'h20
  } ees_state_t;
endpackage

// file: rtl/ees_slave.sv
// Purpose: two-wire serial slave of a small EEPROM with page buffer
// Assumes: scl and sda sampled by mclk, far faster than the bus clock
// Notes: sda is open drain; the pad pulls low while sda_oe is high
`timescale 1ns/10ps
`default_nettype none
`include "ees_cfg.svh"

module ees_slave #(
  parameter bit HAS_STRAPS = 1'b1,
  parameter int unsigned PROG_CYCLES = `EES_PROG_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic select_strap_bit0,
  input wire logic select_strap_bit1,
  input wire logic select_strap_bit2,
  input wire logic wp,
  output logic prog_busy
);
  localparam int AW = `EES_ADDR_W;
  localparam int PW = `EES_PAGE_W;

  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, wp_m, wp_s;
  logic [2:0] sel_m, sel_s;
  logic scl_rise, scl_fall, start_ev, stop_ev, ack_beg, ack_end;
  logic dev_ok, dec_ack, launch, send_nx, commit_en;
  ees_pkg::ees_state_t st_q;
  logic [3:0] cnt_q;
  logic ackph_q, mack_q, ackd_q, wp_lat_q, busy_q, sda_oe_q, sda_o_q;
  logic [7:0] sr_q, tx_q;
  logic [PW-1:0] ahi_q, off_q;
  logic [AW-1:0] addr_q;
  logic [AW-PW-1:0] page_q;
  logic [(1<<PW)-1:0] loaded_q;
  logic [31:0] bcnt_q;
  logic [PW:0] ci_q;
  logic [7:0] pbuf [1<<PW];
  logic [7:0] mem [1<<AW];

  // Two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
      wp_m <= 1'b0;
      wp_s <= 1'b0;
      sel_m <= 3'h0;
      sel_s <= 3'h0;
    end else begin
      scl_m <= scl;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_p <= sda_s;
      wp_m <= wp;
      wp_s <= wp_m;
      sel_m <= {select_strap_bit2, select_strap_bit1, select_strap_bit0};
      sel_s <= sel_m;
    end
  end

  // Bus events; edges seen from the synchronised copies
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;
  assign ack_beg = scl_fall & (cnt_q == 4'h8) & ~ackph_q & (st_q != ees_pkg::EES_IDLE);
  assign ack_end = scl_fall & ackph_q;

  // Address byte compare; straps ignored on the strapless build
  assign dev_ok = (sr_q[7:4] == `EES_TYPE_ID) &&
                  (sr_q[3:1] == (HAS_STRAPS ? sel_s : `EES_NOSTRAP_SEL));

  // Acknowledge decision for the byte just received
  always_comb begin
    dec_ack = 1'b0;
    unique case (st_q)
      ees_pkg::EES_IDLE: dec_ack = 1'b0;
      ees_pkg::EES_DEVA: dec_ack = dev_ok & ~busy_q;
      ees_pkg::EES_AHI: dec_ack = 1'b1;
      ees_pkg::EES_ALO: dec_ack = 1'b1;
      ees_pkg::EES_WDAT: dec_ack = ~wp_lat_q;
      ees_pkg::EES_RDAT: dec_ack = 1'b0;
    endcase
  end

  // Start a data byte after an address ack or a master ack
  assign send_nx = ack_end & (((st_q == ees_pkg::EES_DEVA) & ackd_q & sr_q[0]) |
                              ((st_q == ees_pkg::EES_RDAT) & mack_q));

  // Bit counter and shift-in; data taken on clock rise
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
      ackph_q <= 1'b0;
      sr_q <= 8'h00;
    end else if (start_ev || stop_ev) begin
      cnt_q <= 4'h0;
      ackph_q <= 1'b0;
    end else if (scl_rise && st_q != ees_pkg::EES_IDLE && cnt_q != 4'h8) begin
      sr_q <= {sr_q[6:0], sda_s};
      cnt_q <= cnt_q + 4'h1;
    end else if (ack_beg) begin
      ackph_q <= 1'b1;
    end else if (ack_end) begin
      ackph_q <= 1'b0;
      cnt_q <= 4'h0;
    end
  end

  // Master answer on the ninth rise, and our own ack choice
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mack_q <= 1'b0;
      ackd_q <= 1'b0;
    end else begin
      if (scl_rise && ackph_q) begin
        mack_q <= ~sda_s;
      end
      if (ack_beg) begin
        ackd_q <= dec_ack;
      end
    end
  end

  // Protocol state; anything before START is ignored
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ees_pkg::EES_IDLE;
    end else if (start_ev) begin
      st_q <= ees_pkg::EES_DEVA;
    end else if (stop_ev) begin
      st_q <= ees_pkg::EES_IDLE;
    end else if (ack_end) begin
      unique case (st_q)
        ees_pkg::EES_IDLE: st_q <= ees_pkg::EES_IDLE;
        ees_pkg::EES_DEVA: st_q <= !ackd_q ? ees_pkg::EES_IDLE :
                                   sr_q[0] ? ees_pkg::EES_RDAT : ees_pkg::EES_AHI;
        ees_pkg::EES_AHI: st_q <= ees_pkg::EES_ALO;
        ees_pkg::EES_ALO: st_q <= ees_pkg::EES_WDAT;
        ees_pkg::EES_WDAT: st_q <= ackd_q ? ees_pkg::EES_WDAT : ees_pkg::EES_IDLE;
        ees_pkg::EES_RDAT: st_q <= mack_q ? ees_pkg::EES_RDAT : ees_pkg::EES_IDLE;
      endcase
    end
  end

  // Address, page and protect latch; upper bits of the high byte dropped
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ahi_q <= '0;
      addr_q <= '0;
      page_q <= '0;
      off_q <= '0;
      wp_lat_q <= 1'b0;
    end else if (ack_end && st_q == ees_pkg::EES_AHI) begin
      ahi_q <= sr_q[PW-1:0];
    end else if (ack_end && st_q == ees_pkg::EES_ALO) begin
      addr_q <= {ahi_q, sr_q};
      page_q <= {ahi_q, sr_q[7:PW]};
      off_q <= sr_q[PW-1:0];
      wp_lat_q <= wp_s;
    end else if (ack_end && st_q == ees_pkg::EES_WDAT && ackd_q) begin
      off_q <= off_q + 1'b1;
      addr_q <= {page_q, PW'(off_q + 1'b1)};
    end else if (send_nx) begin
      addr_q <= addr_q + 1'b1;
    end
  end

  // Page buffer loads; each slot flagged so only new bytes commit
  always_ff @(posedge mclk) begin
    if (ack_end && st_q == ees_pkg::EES_WDAT && ackd_q) begin
      pbuf[off_q] <= sr_q;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      loaded_q <= '0;
    end else if (busy_q && bcnt_q == 32'h0) begin
      loaded_q <= '0;
    end else if (start_ev && !busy_q) begin
      loaded_q <= '0;
    end else if (ack_end && st_q == ees_pkg::EES_WDAT && ackd_q) begin
      loaded_q[off_q] <= 1'b1;
    end
  end

  // Programming launch; a write with no accepted data never launches
  assign launch = stop_ev & (st_q == ees_pkg::EES_WDAT) & (|loaded_q) & ~busy_q;

  // Busy timer holds the bus refusal for exactly PROG_CYCLES
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      bcnt_q <= 32'h0;
    end else if (launch) begin
      busy_q <= 1'b1;
      bcnt_q <= 32'(PROG_CYCLES - 1);
    end else if (busy_q) begin
      if (bcnt_q == 32'h0) begin
        busy_q <= 1'b0;
      end else begin
        bcnt_q <= bcnt_q - 32'h1;
      end
    end
  end

  // Commit walk: one slot per clock, far inside the busy window
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ci_q <= '0;
    end else if (launch) begin
      ci_q <= '0;
    end else if (busy_q && !ci_q[PW]) begin
      ci_q <= ci_q + 1'b1;
    end
  end

  assign commit_en = busy_q & ~ci_q[PW] & loaded_q[ci_q[PW-1:0]];

  // Array; erased image is all ones, kept out of reset on purpose
  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = `EES_ERASED;
    end
  end

  always @(posedge mclk) begin
    if (commit_en) begin
      mem[{page_q, ci_q[PW-1:0]}] <= pbuf[ci_q[PW-1:0]];
    end
  end

  // Data line drive; changes land on a falling clock, or on START or STOP
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sda_oe_q <= 1'b0;
      tx_q <= 8'h00;
    end else if (start_ev || stop_ev) begin
      sda_oe_q <= 1'b0;
    end else if (ack_beg) begin
      sda_oe_q <= dec_ack;
    end else if (send_nx) begin
      sda_oe_q <= ~mem[addr_q][7];
      tx_q <= {mem[addr_q][6:0], 1'b0};
    end else if (ack_end) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall && st_q == ees_pkg::EES_RDAT && !ackph_q) begin
      sda_oe_q <= ~tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // Open drain: the driven level is always low
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  assign sda_o = sda_o_q;
  assign sda_oe = sda_oe_q;
  assign prog_busy = busy_q;

  // Helper for checks: length of the busy window
  logic [31:0] bh_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bh_q <= 32'h0;
    end else if (busy_q) begin
      bh_q <= bh_q + 32'h1;
    end else begin
      bh_q <= 32'h0;
    end
  end

  sequence s_addr_refused;
    ack_beg && st_q == ees_pkg::EES_DEVA && (busy_q || !dev_ok);
  endsequence

  sequence s_wp_data;
    ack_beg && st_q == ees_pkg::EES_WDAT && wp_lat_q;
  endsequence

  a_start_seen: assert property (@(posedge mclk) disable iff (!nrst)
    start_ev |=> st_q == ees_pkg::EES_DEVA && cnt_q == 4'h0)
    else $error("START did not open address phase");

  a_stop_idle: assert property (@(posedge mclk) disable iff (!nrst)
    stop_ev |=> st_q == ees_pkg::EES_IDLE && !sda_oe_q)
    else $error("STOP did not return to idle");

  a_addr_silent: assert property (@(posedge mclk) disable iff (!nrst)
    s_addr_refused |=> !sda_oe_q [*8] ##1 !sda_oe_q [*8])
    else $error("Refused address was acknowledged");

  a_wp_refuse: assert property (@(posedge mclk) disable iff (!nrst)
    s_wp_data |=> !sda_oe_q ##0 !ackd_q)
    else $error("Protected data byte acknowledged");

  a_busy_exact: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(busy_q) |-> bh_q == PROG_CYCLES)
    else $error("Busy window length wrong");

  a_launch_busy: assert property (@(posedge mclk) disable iff (!nrst)
    launch |=> busy_q [*8])
    else $error("Programming cycle did not start");

  a_oe_on_fall: assert property (@(posedge mclk) disable iff (!nrst)
    $changed(sda_oe_q) |-> $past(scl_fall) || $past(start_ev) || $past(stop_ev))
    else $error("Data line changed off a falling clock");

  a_page_wrap: assert property (@(posedge mclk) disable iff (!nrst)
    ack_end && st_q == ees_pkg::EES_WDAT && ackd_q && off_q == 5'h1F |=> off_q == 5'h00)
    else $error("Page offset did not wrap");

  a_no_data_no_prog: assert property (@(posedge mclk) disable iff (!nrst)
    stop_ev && loaded_q == '0 && !busy_q |=> !busy_q)
    else $error("Programming without data");

  a_read_advance: assert property (@(posedge mclk) disable iff (!nrst)
    send_nx |=> addr_q == AW'($past(addr_q) + 1'b1))
    else $error("Read address did not advance");
endmodule // ees_slave
`default_nettype wire

// file: verification/ees_master.sv
// Purpose: bus master model that drives the serial clock and data wire
// Assumes: data wire has a pull-up, so a released line reads high
// Notes: clock stands high between frames, 160 ns period inside them
`timescale 1ns/10ps
`default_nettype none
module ees_master (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  // Both lines released at power up
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // All changes land just after a system clock edge
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Data moves only while the clock is low
  task automatic bit_x(input logic b, output logic s);
    sda_m = b;
    hold(4);
    scl = 1'b1;
    hold(8);
    s = sda;
    scl = 1'b0;
    hold(4);
  endtask
  // Also serves as a repeated start from a low clock
  task automatic start();
    sda_m = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_m = 1'b0;
    hold(8);
    scl = 1'b0;
    hold(4);
  endtask
  task automatic stop();
    sda_m = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_m = 1'b1;
    hold(8);
  endtask
  // Ninth slot released so the device can answer
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~mack, s);
  endtask
endmodule // ees_master
`default_nettype wire

// file: verification/ees_slave_bench.sv
// Purpose: self-checking bench of the serial EEPROM slave
// Assumes: short programming count; two slaves share one wire
// Notes: second slave is the strapless build, sharing strap and protect pins
`timescale 1ns/10ps
`default_nettype none
module ees_slave_bench;
  typedef struct packed {logic [7:0] a; logic ack;} ees_row_t;
  localparam int PROG = 400;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic wp = 1'b0;
  logic [2:0] sel = 3'h5;
  logic scl, sda_m, sda_o, sda_oe, busy, sda_o2, sda_oe2, busy2, ack;
  logic [7:0] d;
  logic [7:0] dat_b [4];
  int err_total = 0;
  int cmp_count = 0;
  int busy_n = 0;
  logic busy_d = 1'b0;
  int tries;
  ees_row_t rows [7] = '{'{8'hAA, 1'b1}, '{8'hAB, 1'b1}, '{8'hA0, 1'b1}, '{8'hA1, 1'b1},
    '{8'hBA, 1'b0}, '{8'hAE, 1'b0}, '{8'hA2, 1'b0}};
  // Open-drain wire with pull-up: low if any party pulls
  wire logic sda = sda_m & (sda_oe ? sda_o : 1'b1) & (sda_oe2 ? sda_o2 : 1'b1);
  always #5 mclk = ~mclk;
  // Length of the programming pulse
  // One driver only; restarts on each rising edge of busy
  always @(posedge mclk) begin
    busy_d <= busy;
    if (busy && !busy_d) busy_n <= 1;
    else if (busy) busy_n <= busy_n + 1;
  end
  ees_slave #(.PROG_CYCLES(PROG)) dut (.mclk(mclk), .nrst(nrst), .scl(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .select_strap_bit0(sel[0]), .select_strap_bit1(sel[1]),
    .select_strap_bit2(sel[2]), .wp(wp), .prog_busy(busy));
  ees_slave #(.HAS_STRAPS(1'b0), .PROG_CYCLES(PROG)) dut_nostrap (.mclk(mclk), .nrst(nrst),
    .scl(scl), .sda_i(sda), .sda_o(sda_o2), .sda_oe(sda_oe2), .select_strap_bit0(sel[0]),
    .select_strap_bit1(sel[1]), .select_strap_bit2(sel[2]), .wp(wp), .prog_busy(busy2));
  ees_master bus (.mclk(mclk), .sda(sda), .scl(scl), .sda_m(sda_m));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Select and load a memory address, high byte first
  task automatic addr_phase(input logic [15:0] a);
    bus.start();
    bus.wr_byte(8'hAA, ack);
    chk("addr ack", 1, ack);
    bus.wr_byte(a[15:8], ack);
    chk("hi ack", 1, ack);
    bus.wr_byte(a[7:0], ack);
    chk("lo ack", 1, ack);
  endtask
  task automatic wr_seq(input logic [15:0] a, input int n, input logic dack);
    addr_phase(a);
    for (int i = 0; i < n; i++) begin
      bus.wr_byte(dat_b[i], ack);
      chk("data ack", dack, ack);
    end
    bus.stop();
  endtask
  // Selective read of n bytes, expected values in dat_b
  task automatic rd_seq(input logic [15:0] a, input int n);
    addr_phase(a);
    bus.start();
    bus.wr_byte(8'hAB, ack);
    chk("read addr ack", 1, ack);
    for (int i = 0; i < n; i++) begin
      bus.rd_byte(i < n - 1, d);
      chk("read data", dat_b[i], d);
    end
    bus.stop();
    chk("no program", 0, busy);
  endtask
  // Poll until the device answers, bounded
  task automatic poll();
    tries = 0;
    ack = 1'b0;
    while (ack !== 1'b1 && tries < 20) begin
      bus.start();
      bus.wr_byte(8'hAA, ack);
      bus.stop();
      tries++;
    end
    chk("poll ack", 1, ack);
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    #200000;
    err_total++;
    $display("Error watchdog expected finish seen timeout");
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge mclk);
    #1;
    chk("oe in reset", 0, sda_oe);
    nrst = 1'b1;
    chk("busy after reset", 0, busy);
    chk("drive level", 0, sda_o);
    bus.hold(4);
    $display("test reset done");
    foreach (rows[i]) begin
      bus.start();
      bus.wr_byte(rows[i].a, ack);
      chk("select ack", rows[i].ack, ack);
      if (ack === 1'b1 && rows[i].a[0]) begin
        bus.rd_byte(1'b0, d);
        chk("current read", 8'hFF, d);
      end
      bus.stop();
      chk("no program", 0, busy);
    end
    $display("test select done");
    // Straps are live pins; strapless build ignores them
    sel = 3'h2;
    bus.hold(4);
    bus.start();
    bus.wr_byte(8'hA4, ack);
    chk("new strap ack", 1, ack);
    bus.stop();
    bus.start();
    bus.wr_byte(8'hAA, ack);
    chk("old strap ack", 0, ack);
    bus.stop();
    bus.start();
    bus.wr_byte(8'hA0, ack);
    chk("strapless ack", 1, ack);
    bus.stop();
    sel = 3'h5;
    bus.hold(4);
    $display("test strap done");
    // Three bytes from offset 1E wrap to the page start
    dat_b = '{8'h11, 8'h22, 8'h33, 8'h00};
    wr_seq(16'h013E, 3, 1'b1);
    bus.start();
    bus.wr_byte(8'hAA, ack);
    chk("busy refuses", 0, ack);
    chk("busy flag", 1, busy);
    chk("other busy", 0, busy2);
    bus.stop();
    poll();
    chk("busy length", PROG, busy_n);
    dat_b = '{8'h11, 8'h22, 8'hFF, 8'h00};
    rd_seq(16'h013E, 3);
    dat_b[0] = 8'h33;
    rd_seq(16'h0120, 1);
    $display("test page done");
    // Upper address bits ignored; reads wrap to zero
    dat_b[0] = 8'h5A;
    wr_seq(16'hFFFF, 1, 1'b1);
    poll();
    dat_b = '{8'h5A, 8'hFF, 8'hFF, 8'hFF};
    rd_seq(16'h1FFF, 3);
    $display("test wrap done");
    // Protected write is refused and never programmed
    wp = 1'b1;
    dat_b[0] = 8'h77;
    wr_seq(16'h0200, 1, 1'b0);
    bus.hold(8);
    chk("protect busy", 0, busy);
    wp = 1'b0;
    dat_b[0] = 8'hFF;
    rd_seq(16'h0200, 1);
    $display("test protect done");
    // Reset during programming ends it at once
    dat_b[0] = 8'h44;
    wr_seq(16'h0300, 1, 1'b1);
    bus.hold(20);
    chk("busy before reset", 1, busy);
    nrst = 1'b0;
    bus.hold(2);
    chk("busy in reset", 0, busy);
    nrst = 1'b1;
    bus.hold(4);
    poll();
    chk("polls after reset", 1, tries);
    $display("test midreset done");
    report_and_stop();
  end
endmodule // ees_slave_bench
`default_nettype wire
